// ==== pll_startup_pkg.sv ====
package pll_startup_pkg;

  // ----------------------------------------
  // register map (byte addresses on the config port)
  // ----------------------------------------
  localparam logic [7:0] ADDR_IMAGE_REVISION = 8'h09;
  localparam logic [7:0] ADDR_DEVICE_CONTROL = 8'h0a;
  localparam logic [7:0] ADDR_MARGIN_HIGH = 8'h10;
  localparam logic [7:0] ADDR_MARGIN_LOW = 8'h11;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h48;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_PLL_POWER_DOWN = 6;
  localparam int BIT_CAL_TRIGGER = 1;
  localparam int BIT_AUTO_LOCK = 0;
  localparam int BIT_SW_RESET = 1;
  localparam int MARGIN_HIGH_BITS = 2;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_IMAGE_REVISION = 8'h00;
  localparam logic RST_PLL_POWER_DOWN = 1'b0;
  localparam logic RST_CAL_TRIGGER = 1'b0;
  localparam logic RST_AUTO_LOCK = 1'b1;
  localparam logic [3:0] RST_CTL_RESERVED = 4'h0;
  localparam logic [1:0] RST_MARGIN_HIGH = 2'h0;
  localparam logic [7:0] RST_MARGIN_LOW = 8'h80;

  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_FETCH,
    ST_HALT,
    ST_CAL,
    ST_LOCK,
    ST_RUN,
    ST_POWERDOWN
  } seq_type;

endpackage

// ==== pll_startup_control_regs.sv ====
// How it works
// R1: after any reset or image commit, fetch image revision from non-volatile memory.
// R2: image revision is 8-bit read-only, 0x00 until loaded, writes ignored.
// R3: control bit 6 powers the PLL down when 1; resets to 0.
// R4: with power-down 0, enable and calibrate the PLL after hardware reset.
// R5: setting power-down disables the PLL and holds calibration in reset.
// R6: clearing power-down re-enables the PLL and restarts calibration.
// R7: a 0-to-1 write on control bit 1 starts a frequency calibration.
// R8: calibration trigger clears itself when calibration completes; resets to 0.
// R9: during reset startup, autostart decides calibration, not the trigger bit.
// R10: autostart (bit 0, reset 1) locks after reset then enables outputs alone.
// R11: device reset comes from power-on reset or the software reset bit.
// R12: with autostart 0, halt after configuration; no lock attempt.
// R13: after halting, host setting autostart to 1 starts the lock sequence.
// R14: margin high register holds two offset bits in [1:0], reset 0x0.
// R15: margin low byte holds offset bits [9:2], read-write, reset 0x80.
// R16: outputs enable only after calibration and lock; off while powered down.
module pll_startup_control_regs #(
  parameter int REV_WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic imageCommitDone,
  output logic revFetchReq,
  input wire logic revFetchValid,
  input wire logic [REV_WIDTH-1:0] revFetchData,
  output logic pllEnable,
  output logic calReset,
  output logic calStart,
  input wire logic calDone,
  input wire logic pllLocked,
  output logic outputsEnable,
  output logic [9:0] marginOffset
);

  // the revision register is a byte wide; any other width would not fit the read mux
  if (REV_WIDTH != 8) begin : g_bad_width
    $error("image revision must be 8 bits");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] imageRevision;
    logic pllPowerDown;
    logic [3:0] ctlReserved;
    logic calTrigger;
    logic autoLock;
    logic [1:0] marginHigh;
    logic [7:0] marginLow;
    pll_startup_pkg::seq_type seq;
    logic fetchPending;
    logic calBusy;
    logic doneArmed;
    logic calStartPulse;
    logic [1:0] doneSync;
    logic [1:0] lockSync;
    logic [1:0] validSync;
    logic [1:0] commitSync;
    logic commitPrev;
    logic [7:0] rdata;
  } state_type;

  state_type cur_q;
  state_type nxt_d;

  logic ctlWrite;
  logic swReset;
  logic calDoneS;
  logic lockS;
  logic validS;
  logic commitRise;
  logic trigSet;

  assign ctlWrite = regWrite && regAddr == pll_startup_pkg::ADDR_DEVICE_CONTROL;
  assign trigSet = ctlWrite && regWdata[pll_startup_pkg::BIT_CAL_TRIGGER] && !cur_q.calTrigger;
  // software reset is a pulse, not a stored bit; it re-runs the startup
  assign swReset = regWrite && regAddr == pll_startup_pkg::ADDR_SOFT_RESET
                   && regWdata[pll_startup_pkg::BIT_SW_RESET];
  assign calDoneS = cur_q.doneSync[1];
  assign lockS = cur_q.lockSync[1];
  assign validS = cur_q.validSync[1];
  assign commitRise = cur_q.commitSync[1] && !cur_q.commitPrev;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_d = cur_q;
    nxt_d.calStartPulse = 1'b0;
    nxt_d.doneSync = {cur_q.doneSync[0], calDone};
    nxt_d.lockSync = {cur_q.lockSync[0], pllLocked};
    nxt_d.validSync = {cur_q.validSync[0], revFetchValid};
    nxt_d.commitSync = {cur_q.commitSync[0], imageCommitDone};
    nxt_d.commitPrev = cur_q.commitSync[1];

    // image revision only moves from the fetch or a software reset, never from a host write
    if (cur_q.fetchPending && validS) begin
      nxt_d.imageRevision = revFetchData; // [R1] [R2]
      nxt_d.fetchPending = 1'b0;
    end
    // a commit landing with a finished fetch still asks again
    if (commitRise) begin
      nxt_d.fetchPending = 1'b1; // [R1]
    end

    if (ctlWrite) begin
      nxt_d.pllPowerDown = regWdata[pll_startup_pkg::BIT_PLL_POWER_DOWN]; // [R3]
      nxt_d.ctlReserved = regWdata[5:2];
      nxt_d.autoLock = regWdata[pll_startup_pkg::BIT_AUTO_LOCK];
      if (trigSet) begin
        nxt_d.calTrigger = 1'b1; // [R7]
      end
    end
    if (regWrite && regAddr == pll_startup_pkg::ADDR_MARGIN_HIGH) begin
      nxt_d.marginHigh = regWdata[pll_startup_pkg::MARGIN_HIGH_BITS-1:0]; // [R14]
    end
    if (regWrite && regAddr == pll_startup_pkg::ADDR_MARGIN_LOW) begin
      nxt_d.marginLow = regWdata; // [R15]
    end

    unique case (cur_q.seq)
      pll_startup_pkg::ST_FETCH: begin
        // configuration phase ends once the revision is in
        if (!cur_q.fetchPending) begin
          if (cur_q.pllPowerDown) begin
            nxt_d.seq = pll_startup_pkg::ST_POWERDOWN;
          end else if (cur_q.autoLock) begin // [R9] [R10]
            nxt_d.seq = pll_startup_pkg::ST_CAL; // [R4]
            nxt_d.calStartPulse = 1'b1;
          end else begin
            nxt_d.seq = pll_startup_pkg::ST_HALT; // [R12]
          end
        end
      end
      pll_startup_pkg::ST_HALT: begin
        if (ctlWrite && regWdata[pll_startup_pkg::BIT_AUTO_LOCK]
            && !regWdata[pll_startup_pkg::BIT_PLL_POWER_DOWN]) begin
          nxt_d.seq = pll_startup_pkg::ST_CAL; // [R13]
          nxt_d.calStartPulse = 1'b1;
        end
      end
      pll_startup_pkg::ST_CAL: begin
        // done of the previous calibration lingers in the synchroniser
        if (calDoneS && cur_q.doneArmed) begin
          nxt_d.seq = pll_startup_pkg::ST_LOCK;
        end
      end
      pll_startup_pkg::ST_LOCK: begin
        if (lockS) begin
          nxt_d.seq = pll_startup_pkg::ST_RUN;
        end
      end
      pll_startup_pkg::ST_RUN: begin
        if (!lockS) begin
          nxt_d.seq = pll_startup_pkg::ST_LOCK;
        end
      end
      pll_startup_pkg::ST_POWERDOWN: begin
        if (!cur_q.pllPowerDown) begin
          nxt_d.seq = pll_startup_pkg::ST_CAL; // [R6]
          nxt_d.calStartPulse = 1'b1;
        end
      end
    endcase

    // host trigger recalibrates only from ST_CAL, ST_LOCK or ST_RUN, and only while no calibration is busy
    if (nxt_d.calTrigger && !cur_q.calBusy && cur_q.seq != pll_startup_pkg::ST_FETCH
        && cur_q.seq != pll_startup_pkg::ST_POWERDOWN
        && cur_q.seq != pll_startup_pkg::ST_HALT) begin
      nxt_d.seq = pll_startup_pkg::ST_CAL; // [R7] [R9]
      nxt_d.calStartPulse = 1'b1;
    end
    // done only counts after it was seen low once since the start pulse
    if (nxt_d.calStartPulse) begin
      nxt_d.calBusy = 1'b1;
      nxt_d.doneArmed = 1'b0;
    end else if (cur_q.calBusy && !calDoneS) begin
      nxt_d.doneArmed = 1'b1;
    end else if (cur_q.calBusy && calDoneS && cur_q.doneArmed) begin
      nxt_d.calBusy = 1'b0;
      // a trigger written in the same cycle wins over the self-clear
      if (!trigSet) begin
        nxt_d.calTrigger = 1'b0; // [R8]
      end
    end

    if (cur_q.pllPowerDown && cur_q.seq != pll_startup_pkg::ST_FETCH) begin
      nxt_d.seq = pll_startup_pkg::ST_POWERDOWN; // [R5]
      nxt_d.calBusy = 1'b0;
      nxt_d.calStartPulse = 1'b0;
      nxt_d.calTrigger = 1'b0;
    end

    // software reset restarts like power-on, control and revision back to defaults; margin registers keep their values
    if (swReset) begin // [R11]
      nxt_d.seq = pll_startup_pkg::ST_FETCH;
      nxt_d.fetchPending = 1'b1; // [R1]
      nxt_d.imageRevision = pll_startup_pkg::RST_IMAGE_REVISION;
      nxt_d.pllPowerDown = pll_startup_pkg::RST_PLL_POWER_DOWN;
      nxt_d.ctlReserved = pll_startup_pkg::RST_CTL_RESERVED;
      nxt_d.calTrigger = pll_startup_pkg::RST_CAL_TRIGGER;
      nxt_d.autoLock = pll_startup_pkg::RST_AUTO_LOCK;
      nxt_d.calBusy = 1'b0;
      nxt_d.calStartPulse = 1'b0;
    end

    unique case (regAddr)
      pll_startup_pkg::ADDR_IMAGE_REVISION: nxt_d.rdata = cur_q.imageRevision;
      pll_startup_pkg::ADDR_DEVICE_CONTROL: nxt_d.rdata = {1'b0, cur_q.pllPowerDown,
        cur_q.ctlReserved, cur_q.calTrigger, cur_q.autoLock};
      pll_startup_pkg::ADDR_MARGIN_HIGH: nxt_d.rdata = {6'h00, cur_q.marginHigh};
      pll_startup_pkg::ADDR_MARGIN_LOW: nxt_d.rdata = cur_q.marginLow;
      default: nxt_d.rdata = 8'h00;
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_q <= '{imageRevision: pll_startup_pkg::RST_IMAGE_REVISION,
                 pllPowerDown: pll_startup_pkg::RST_PLL_POWER_DOWN,
                 ctlReserved: pll_startup_pkg::RST_CTL_RESERVED,
                 calTrigger: pll_startup_pkg::RST_CAL_TRIGGER,
                 autoLock: pll_startup_pkg::RST_AUTO_LOCK,
                 marginHigh: pll_startup_pkg::RST_MARGIN_HIGH,
                 marginLow: pll_startup_pkg::RST_MARGIN_LOW,
                 seq: pll_startup_pkg::ST_FETCH,
                 fetchPending: 1'b1,
                 default: '0};
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign regRdata = cur_q.rdata;
  assign revFetchReq = cur_q.fetchPending;
  assign pllEnable = cur_q.seq != pll_startup_pkg::ST_POWERDOWN; // [R3] [R5]
  assign calReset = cur_q.seq == pll_startup_pkg::ST_POWERDOWN; // [R5]
  assign calStart = cur_q.calStartPulse;
  assign outputsEnable = cur_q.seq == pll_startup_pkg::ST_RUN && !cur_q.pllPowerDown; // [R16]
  assign marginOffset = {cur_q.marginLow, cur_q.marginHigh}; // [R14] [R15]

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_rev_write_ignored: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R2]
    regWrite && regAddr == pll_startup_pkg::ADDR_IMAGE_REVISION && !swReset
    && !(cur_q.fetchPending && validS) |=> $stable(cur_q.imageRevision))
    else $error("image revision changed by host write");
  a_commit_fetch: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R1]
    commitRise |=> revFetchReq) else $error("commit did not request revision fetch");
  a_pdn_disables: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R5]
    cur_q.pllPowerDown && cur_q.seq != pll_startup_pkg::ST_FETCH && !swReset
    |=> !pllEnable && calReset) else $error("power down did not disable pll");
  a_pdn_restart: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R6]
    cur_q.seq == pll_startup_pkg::ST_POWERDOWN && !cur_q.pllPowerDown && !swReset
    |=> calStart && pllEnable) else $error("clearing power down did not recalibrate");
  a_trigger_clear: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R8]
    cur_q.calBusy && calDoneS && cur_q.doneArmed && !nxt_d.calStartPulse && !trigSet
    |=> !cur_q.calTrigger) else $error("calibration trigger did not self-clear");
  a_halt_no_lock: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R12]
    cur_q.seq == pll_startup_pkg::ST_HALT && !ctlWrite && !swReset
    |=> cur_q.seq == pll_startup_pkg::ST_HALT) else $error("halted device left halt");
  a_halt_resume: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R13]
    cur_q.seq == pll_startup_pkg::ST_HALT && ctlWrite && !swReset
    && regWdata[pll_startup_pkg::BIT_AUTO_LOCK]
    && !regWdata[pll_startup_pkg::BIT_PLL_POWER_DOWN]
    |=> calStart ##1 cur_q.calBusy) else $error("autostart write did not start lock");
  a_swreset_refetch: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R11]
    swReset |=> revFetchReq && cur_q.autoLock && !outputsEnable)
    else $error("software reset did not restart");
  a_out_needs_lock: assert property (@(posedge ref_clk) disable iff (!reset_n) // [R16]
    outputsEnable |-> $past(lockS) && !cur_q.pllPowerDown && !cur_q.calBusy)
    else $error("outputs enabled without lock");

endmodule

// ==== pll_far_side_model.sv ====
module pll_far_side_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic revFetchReq,
  input wire logic calStart,
  input wire logic calReset,
  input wire logic pllEnable,
  input wire logic [7:0] revValue,
  input wire logic [5:0] answerDelay,
  output logic revFetchValid,
  output logic [7:0] revFetchData,
  output logic calDone,
  output logic pllLocked
);
  timeunit 1ns;
  timeprecision 1ps;
  int fetchCnt;
  int calCnt;
  // ----------------------------------------
  // nvm fetch, calibration and lock, prompt or slow by answerDelay
  // ----------------------------------------
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fetchCnt <= 0;
      calCnt <= -1;
      revFetchValid <= 1'b0;
      revFetchData <= 8'h5a;
      calDone <= 1'b0;
      pllLocked <= 1'b0;
    end else begin
      fetchCnt <= revFetchReq ? fetchCnt + 1 : 0;
      // data toggles whenever it is not held, so a stale value never looks valid
      if (!revFetchValid) revFetchData <= ~revFetchData;
      if (revFetchReq && fetchCnt == int'(answerDelay)) begin
        revFetchValid <= 1'b1;
        revFetchData <= revValue;
      end else if (!revFetchReq) begin
        revFetchValid <= 1'b0;
      end
      if (calStart || calReset) begin
        calDone <= 1'b0;
        calCnt <= calReset ? -1 : int'(answerDelay) + 3;
      end else if (calCnt > 0) begin
        calCnt <= calCnt - 1;
      end else if (calCnt == 0) begin
        calDone <= 1'b1;
        calCnt <= -1;
      end
      pllLocked <= pllEnable && calDone;
    end
  end
endmodule

// ==== pll_startup_control_regs_tb.sv ====
module pll_startup_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, reset_n, regWrite, imageCommitDone, revFetchReq, revFetchValid;
  logic calReset, calStart, calDone, pllLocked, pllEnable, outputsEnable;
  logic [7:0] regAddr, regWdata, regRdata, revFetchData, revValue;
  logic [7:0] ctlModel, revModel, hiModel, loModel;
  logic [5:0] answerDelay;
  logic [9:0] marginOffset;
  int errCount, checksDone, calStarts, cycles, n;

  pll_startup_control_regs #(.REV_WIDTH(8)) pll_startup_control_regs_i (.ref_clk, .reset_n,
    .regWrite, .regAddr, .regWdata, .regRdata, .imageCommitDone, .revFetchReq, .revFetchValid,
    .revFetchData, .pllEnable, .calReset, .calStart, .calDone, .pllLocked, .outputsEnable,
    .marginOffset);
  pll_far_side_model pll_far_side_model_i (.ref_clk, .reset_n, .revFetchReq, .calStart,
    .calReset, .pllEnable, .revValue, .answerDelay, .revFetchValid, .revFetchData, .calDone,
    .pllLocked);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (calStart === 1'b1) calStarts++;
    if (cycles == 20000) begin
      errCount++;
      tallyAndFinish();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(posedge ref_clk);
    #1 regWrite = 1'b0;
    if (a == 8'h0a) ctlModel = d & 8'h7d;
    if (a == 8'h10) hiModel = d & 8'h03;
    if (a == 8'h11) loModel = d;
    if (a == 8'h48 && d[1]) begin
      ctlModel = 8'h01;
      revModel = 8'h00;
    end
  endtask

  // every read compares under the mask the caller passes; 8'hfd leaves out bit1 of control
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] mask);
    @(posedge ref_clk);
    #1 regAddr = a;
    repeat (2) @(posedge ref_clk);
    #1 chk({2'b00, regRdata & mask}, {2'b00, exp & mask}, "register read");
  endtask

  task automatic waitOut(input logic v);
    for (int i = 0; i < 300 && outputsEnable !== v; i++) @(posedge ref_clk);
    #1 chk({9'h000, outputsEnable}, {9'h000, v}, "outputs enable");
  endtask

  task automatic endTest(input string name);
    $display("test done: %s (checks %0d)", name, checksDone);
  endtask

  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(65107));
    {reset_n, regWrite, imageCommitDone, regAddr, regWdata} = '0;
    {ctlModel, revModel, hiModel, loModel} = {8'h01, 8'h00, 8'h00, 8'h80};
    revValue = 8'($urandom);
    answerDelay = 6'h1e;
    repeat (3) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    chk({9'h000, revFetchReq}, 10'h001, "fetch request");
    rd(8'h09, 8'h00, 8'hff);
    rd(8'h0a, ctlModel, 8'hff);
    rd(8'h10, hiModel, 8'hff);
    rd(8'h11, loModel, 8'hff);
    chk(marginOffset, 10'h200, "margin reset");
    waitOut(1'b1);
    revModel = revValue;
    chk(10'(calStarts), 10'h001, "startup cal");
    wr(8'h09, ~revValue);
    rd(8'h09, revModel, 8'hff);
    endTest("startup");
    for (int i = 0; i < 4; i++) begin
      wr(8'h10, 8'($urandom));
      wr(8'h11, 8'($urandom));
      rd(8'h10, hiModel, 8'hff);
      rd(8'h11, loModel, 8'hff);
      chk(marginOffset, {loModel, hiModel[1:0]}, "margin offset");
    end
    endTest("margin");
    wr(8'h0a, 8'h41);
    repeat (2) @(posedge ref_clk);
    #1 chk({pllEnable, calReset, outputsEnable}, 10'h002, "power down");
    rd(8'h0a, ctlModel, 8'hfd);
    n = calStarts;
    wr(8'h0a, 8'h01);
    waitOut(1'b1);
    chk(10'(calStarts - n), 10'h001, "restart cal");
    endTest("power down");
    answerDelay = 6'h08;
    n = calStarts;
    wr(8'h0a, 8'h03);
    rd(8'h0a, 8'h03, 8'hff);
    repeat (60) @(posedge ref_clk);
    rd(8'h0a, 8'h01, 8'hff);
    chk(10'(calStarts - n), 10'h001, "triggered cal");
    waitOut(1'b1);
    endTest("trigger");
    revValue = 8'($urandom);
    imageCommitDone = 1'b1;
    repeat (60) @(posedge ref_clk);
    #1 imageCommitDone = 1'b0;
    revModel = revValue;
    rd(8'h09, revModel, 8'hff);
    endTest("commit");
    answerDelay = 6'h1e;
    revValue = 8'($urandom);
    wr(8'h48, 8'h02);
    wr(8'h0a, 8'h02);
    ctlModel = 8'h00;
    n = calStarts;
    repeat (100) @(posedge ref_clk);
    #1 chk({outputsEnable, 9'(calStarts - n)}, 10'h000, "halted");
    revModel = revValue;
    rd(8'h09, revModel, 8'hff);
    rd(8'h11, loModel, 8'hff);
    wr(8'h0a, 8'h01);
    waitOut(1'b1);
    chk({9'h000, calStarts > n}, 10'h001, "lock after autostart");
    endTest("software reset");
    tallyAndFinish();
  end
endmodule
